// >>> hdl/eep_pkg.sv
// Shared constants for the serial EEPROM read link and its bus master.
package eep_pkg;
   // ==========================================================
   // Clock and link timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int SCL_QUARTER_NS = 250;
   localparam int SCL_QUARTER_CYC = SCL_QUARTER_NS / CLK_PERIOD_NS;
   localparam int DIV_W = 4;
   // ==========================================================
   // Select byte and address layout
   localparam logic [3:0] TYPE_ARRAY = 4'hA;
   localparam logic [3:0] TYPE_ID_PAGE = 4'hB;
   localparam int SEL_TYPE_MSB = 7;
   localparam int SEL_TYPE_LSB = 4;
   localparam int SEL_STRAP_MSB = 3;
   localparam int SEL_STRAP_LSB = 1;
   localparam int SEL_READ_BIT = 0;
   localparam int LOCK_SEL_HI_BIT = 2;
   localparam int ADDR_W = 15;
   localparam int ID_ADDR_W = 6;
   localparam int MEM_BYTES = 32768;
   localparam int ID_BYTES = 64;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [14:0] ADDR_RESET = 15'h0000;
   // ==========================================================
   // Byte phases of an instruction
   localparam logic [1:0] PH_SELECT = 2'h0;
   localparam logic [1:0] PH_ADDR_HI = 2'h1;
   localparam logic [1:0] PH_ADDR_LO = 2'h2;
   localparam logic [1:0] PH_DATA = 2'h3;
   localparam logic [3:0] LAST_BIT = 4'h8;
endpackage : eep_pkg

// >>> hdl/eep_bus_if.sv
// Two-wire link between the bus master and the EEPROM end.
`timescale 1ns/1ps
`default_nettype none
interface eep_bus_if;
   logic scl;
   logic m_sda_oe;
   logic s_sda_oe;
   logic sda;
   // Open drain: the line is low while either end pulls it.
   assign sda = ~(m_sda_oe | s_sda_oe);
   modport master (output scl, output m_sda_oe, input sda);
   modport slave (input scl, output s_sda_oe, input sda);
endinterface : eep_bus_if
`default_nettype wire

// >>> hdl/eep_slave.sv
// EEPROM end of the link: read, current read, ID page and busy polling.
`timescale 1ns/1ps
`default_nettype none
module eep_slave (
   input  wire logic                      clk_in,
   input  wire logic                      srst_in,
   eep_bus_if.slave                       bus,
   input  wire logic                      write_protect_input_in,
   input  wire logic [2:0]                chip_select_straps_in,
   input  wire logic                      write_cycle_busy_in,
   input  wire logic                      id_page_locked_in,
   input  wire logic                      load_en_in,
   input  wire logic                      load_id_in,
   input  wire logic [eep_pkg::ADDR_W-1:0] load_addr_in,
   input  wire logic [7:0]                load_data_in,
   output logic                           init_busy_out,
   output logic [eep_pkg::ADDR_W-1:0]     addr_count_out
);
   import eep_pkg::*;

   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_RX   = 7'h02,
      S_DEC  = 7'h04,
      S_ACK  = 7'h08,
      S_TX   = 7'h10,
      S_MACK = 7'h20,
      S_TXW  = 7'h40
   } eep_state_e;

   // ==========================================================
   // Pin synchronisers
   // Order: straps, protect, busy, locked, scl, sda.
   logic [7:0] sync_a_r;
   logic [7:0] sync_b_r;
   logic [1:0] prev_r;
   logic       scl_s;
   logic       sda_s;
   logic [2:0] straps_s;
   logic       wp_s;
   logic       busy_s;
   logic       locked_s;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_seen;
   logic       stop_seen;

   always_ff @(posedge clk_in) begin
      sync_a_r <= {chip_select_straps_in, write_protect_input_in,
                   write_cycle_busy_in, id_page_locked_in,
                   bus.scl, bus.sda};
      sync_b_r <= sync_a_r;
      prev_r   <= sync_b_r[1:0];
   end

   assign straps_s = sync_b_r[7:5];
   assign wp_s     = sync_b_r[4];
   assign busy_s   = sync_b_r[3];
   assign locked_s = sync_b_r[2];
   assign scl_s    = sync_b_r[1];
   assign sda_s    = sync_b_r[0];
   assign scl_rise = scl_s & ~prev_r[1];
   assign scl_fall = ~scl_s & prev_r[1];
   assign start_seen = scl_s & prev_r[1] & prev_r[0] & ~sda_s;
   assign stop_seen  = scl_s & prev_r[1] & ~prev_r[0] & sda_s;

   // ==========================================================
   // Storage and erase sweep
   logic [7:0]          mem [0:MEM_BYTES-1];
   logic [7:0]          id_mem [0:ID_BYTES-1];
   logic [ADDR_W-1:0]   init_cnt_r;
   logic [ADDR_W-1:0]   init_cnt_nxt;
   logic                init_busy_r;
   logic                init_busy_nxt;
   logic [7:0]          arr_rd_r;
   logic [7:0]          id_rd_r;
   logic [ADDR_W-1:0]   addr_r;
   logic [ID_ADDR_W-1:0] id_addr_r;

   always_comb begin
      init_cnt_nxt  = init_cnt_r;
      init_busy_nxt = init_busy_r;
      if (init_busy_r) begin
         init_cnt_nxt = init_cnt_r + 1'b1;
         if (&init_cnt_r) begin
            init_busy_nxt = 1'b0;
         end
      end
   end

   // A sweep replaces a reset of the array, which would cost a port per
   // byte; the link stays busy until every byte reads FFh.
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         init_cnt_r  <= ADDR_RESET;
         init_busy_r <= 1'b1;
      end else begin
         init_cnt_r  <= init_cnt_nxt;
         init_busy_r <= init_busy_nxt;
      end
      if (init_busy_r) begin
         mem[init_cnt_r] <= ERASED_BYTE;
         id_mem[init_cnt_r[ID_ADDR_W-1:0]] <= ERASED_BYTE;
      end else if (load_en_in && load_id_in) begin
         id_mem[load_addr_in[ID_ADDR_W-1:0]] <= load_data_in;
      end else if (load_en_in) begin
         mem[load_addr_in] <= load_data_in;
      end
      arr_rd_r <= mem[addr_r];
      id_rd_r  <= id_mem[id_addr_r];
   end

   // ==========================================================
   // Protocol engine
   eep_state_e           state_r;
   eep_state_e           state_nxt;
   logic [2:0]           bit_cnt_r;
   logic [2:0]           bit_cnt_nxt;
   logic [7:0]           shift_r;
   logic [7:0]           shift_nxt;
   logic [1:0]           phase_r;
   logic [1:0]           phase_nxt;
   logic                 is_read_r;
   logic                 is_read_nxt;
   logic                 is_id_r;
   logic                 is_id_nxt;
   logic                 ack_ok_r;
   logic                 ack_ok_nxt;
   logic [7:0]           addr_hi_r;
   logic [7:0]           addr_hi_nxt;
   logic [ADDR_W-1:0]    addr_nxt;
   logic [ID_ADDR_W-1:0] id_addr_nxt;
   logic                 oe_r;
   logic                 oe_nxt;
   logic [7:0]           rx_byte;
   logic [7:0]           out_byte;
   logic                 busy;

   assign rx_byte  = {shift_r[6:0], sda_s};
   assign out_byte = is_id_r ? id_rd_r : arr_rd_r;
   assign busy     = busy_s | init_busy_r;

   always_comb begin
      state_nxt   = state_r;
      bit_cnt_nxt = bit_cnt_r;
      shift_nxt   = shift_r;
      phase_nxt   = phase_r;
      is_read_nxt = is_read_r;
      is_id_nxt   = is_id_r;
      ack_ok_nxt  = ack_ok_r;
      addr_hi_nxt = addr_hi_r;
      addr_nxt    = addr_r;
      id_addr_nxt = id_addr_r;
      oe_nxt      = oe_r;
      if (start_seen) begin
         // Any pending instruction is dropped here.
         state_nxt   = S_RX;
         bit_cnt_nxt = 3'h0;
         phase_nxt   = PH_SELECT;
         oe_nxt      = 1'b0;
      end else if (stop_seen) begin
         state_nxt = S_IDLE;
         oe_nxt    = 1'b0;
      end else begin
         case (state_r)
            S_IDLE: begin
               oe_nxt = 1'b0;
            end
            S_RX: begin
               if (scl_rise) begin
                  shift_nxt   = rx_byte;
                  bit_cnt_nxt = bit_cnt_r + 1'b1;
                  if (bit_cnt_r == 3'h7) begin
                     state_nxt  = S_DEC;
                     ack_ok_nxt = ~busy;
                     case (phase_r)
                        PH_SELECT: begin
                           is_read_nxt = rx_byte[SEL_READ_BIT];
                           is_id_nxt = rx_byte[SEL_TYPE_MSB:SEL_TYPE_LSB]
                                       == TYPE_ID_PAGE;
                           ack_ok_nxt = ~busy
                              && (rx_byte[SEL_TYPE_MSB:SEL_TYPE_LSB]
                                  == TYPE_ARRAY || is_id_nxt)
                              && rx_byte[SEL_STRAP_MSB:SEL_STRAP_LSB]
                                 == straps_s;
                        end
                        PH_ADDR_HI: begin
                           addr_hi_nxt = rx_byte;
                        end
                        PH_ADDR_LO: begin
                           if (is_id_r) begin
                              id_addr_nxt = rx_byte[ID_ADDR_W-1:0];
                           end else begin
                              addr_nxt = {addr_hi_r[6:0], rx_byte};
                           end
                        end
                        default: begin
                           // Probe byte only; nothing is ever stored.
                           ack_ok_nxt = ~busy
                              && (is_id_r ? ~locked_s : ~wp_s);
                        end
                     endcase
                  end
               end
            end
            S_DEC: begin
               if (scl_fall) begin
                  oe_nxt    = ack_ok_r;
                  state_nxt = ack_ok_r ? S_ACK : S_IDLE;
               end
            end
            S_ACK: begin
               if (scl_fall) begin
                  bit_cnt_nxt = 3'h0;
                  if (phase_r == PH_SELECT && is_read_r) begin
                     // Read bytes ignore the protect input entirely.
                     shift_nxt = out_byte;
                     oe_nxt    = ~out_byte[7];
                     state_nxt = S_TX;
                  end else begin
                     oe_nxt    = 1'b0;
                     state_nxt = S_RX;
                     if (phase_r != PH_DATA) begin
                        phase_nxt = phase_r + 1'b1;
                     end
                  end
               end
            end
            S_TX: begin
               if (scl_fall) begin
                  if (bit_cnt_r == 3'h7) begin
                     oe_nxt    = 1'b0;
                     state_nxt = S_MACK;
                  end else begin
                     bit_cnt_nxt = bit_cnt_r + 1'b1;
                     shift_nxt   = {shift_r[6:0], 1'b0};
                     oe_nxt      = ~shift_r[6];
                  end
               end
            end
            S_MACK: begin
               if (scl_rise) begin
                  // Counter widths wrap 7FFFh and 3Fh back to zero.
                  if (is_id_r) begin
                     id_addr_nxt = id_addr_r + 1'b1;
                  end else begin
                     addr_nxt = addr_r + 1'b1;
                  end
                  state_nxt = sda_s ? S_IDLE : S_TXW;
               end
            end
            S_TXW: begin
               if (scl_fall) begin
                  bit_cnt_nxt = 3'h0;
                  shift_nxt   = out_byte;
                  oe_nxt      = ~out_byte[7];
                  state_nxt   = S_TX;
               end
            end
            default: begin
               state_nxt = S_IDLE;
               oe_nxt    = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         state_r   <= S_IDLE;
         bit_cnt_r <= 3'h0;
         shift_r   <= 8'h00;
         phase_r   <= PH_SELECT;
         is_read_r <= 1'b0;
         is_id_r   <= 1'b0;
         ack_ok_r  <= 1'b0;
         addr_hi_r <= 8'h00;
         addr_r    <= ADDR_RESET;
         id_addr_r <= ADDR_RESET[ID_ADDR_W-1:0];
         oe_r      <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         shift_r   <= shift_nxt;
         phase_r   <= phase_nxt;
         is_read_r <= is_read_nxt;
         is_id_r   <= is_id_nxt;
         ack_ok_r  <= ack_ok_nxt;
         addr_hi_r <= addr_hi_nxt;
         addr_r    <= addr_nxt;
         id_addr_r <= id_addr_nxt;
         oe_r      <= oe_nxt;
      end
   end

   assign bus.s_sda_oe   = oe_r;
   assign init_busy_out  = init_busy_r;
   assign addr_count_out = addr_r;
endmodule : eep_slave
`default_nettype wire

// >>> hdl/eep_master.sv
// Byte-level bus master end of the EEPROM link.
`timescale 1ns/1ps
`default_nettype none
module eep_master (
   input  wire logic       clk_in,
   input  wire logic       srst_in,
   eep_bus_if.master       bus,
   input  wire logic       cmd_valid_in,
   output logic            cmd_ready_out,
   input  wire logic       cmd_start_in,
   input  wire logic       cmd_stop_in,
   input  wire logic       cmd_skip_byte_in,
   input  wire logic       cmd_read_in,
   input  wire logic       cmd_ack_in,
   input  wire logic [7:0] cmd_wdata_in,
   output logic            rsp_valid_out,
   output logic [7:0]      rsp_data_out,
   output logic            rsp_ack_out
);
   import eep_pkg::*;

   typedef enum logic [3:0] {
      M_IDLE  = 4'h1,
      M_START = 4'h2,
      M_BITS  = 4'h4,
      M_STOP  = 4'h8
   } eep_mstate_e;

   // ==========================================================
   // Line input synchroniser
   logic sda_a_r;
   logic sda_b_r;

   always_ff @(posedge clk_in) begin
      sda_a_r <= bus.sda;
      sda_b_r <= sda_a_r;
   end

   // ==========================================================
   // Quarter-bit sequencer
   eep_mstate_e       st_r, st_nxt;
   logic [DIV_W-1:0]  div_r, div_nxt;
   logic [1:0]        q_r, q_nxt;
   logic [3:0]        bit_r, bit_nxt;
   logic [7:0]        tx_r, tx_nxt;
   logic [7:0]        rx_r, rx_nxt;
   logic              scl_r, scl_nxt;
   logic              oe_r, oe_nxt;
   logic              stop_r, stop_nxt;
   logic              skip_r, skip_nxt;
   logic              read_r, read_nxt;
   logic              ack_r, ack_nxt;
   logic              gotack_r, gotack_nxt;
   logic              done_r, done_nxt;
   logic              tick;

   assign cmd_ready_out = (st_r == M_IDLE);
   assign tick = (div_r == DIV_W'(SCL_QUARTER_CYC - 1));

   always_comb begin
      st_nxt = st_r;
      div_nxt = tick ? '0 : div_r + 1'b1;
      q_nxt = tick ? q_r + 1'b1 : q_r;
      bit_nxt = bit_r;
      tx_nxt = tx_r;
      rx_nxt = rx_r;
      scl_nxt = scl_r;
      oe_nxt = oe_r;
      stop_nxt = stop_r;
      skip_nxt = skip_r;
      read_nxt = read_r;
      ack_nxt = ack_r;
      gotack_nxt = gotack_r;
      done_nxt = 1'b0;
      case (st_r)
         M_IDLE: begin
            div_nxt = '0;
            q_nxt = 2'h0;
            if (cmd_valid_in) begin
               stop_nxt = cmd_stop_in;
               skip_nxt = cmd_skip_byte_in;
               read_nxt = cmd_read_in;
               ack_nxt = cmd_ack_in;
               tx_nxt = cmd_wdata_in;
               bit_nxt = 4'h0;
               st_nxt = cmd_start_in ? M_START
                      : (cmd_skip_byte_in ? M_STOP : M_BITS);
            end
         end
         M_START: begin
            if (tick) begin
               case (q_r)
                  2'h0: oe_nxt = 1'b0;
                  2'h1: scl_nxt = 1'b1;
                  2'h2: oe_nxt = 1'b1;
                  default: begin
                     scl_nxt = 1'b0;
                     st_nxt = skip_r ? M_STOP : M_BITS;
                  end
               endcase
            end
         end
         M_BITS: begin
            if (tick) begin
               case (q_r)
                  2'h0: begin
                     // Data moves only while the clock is low.
                     if (bit_r != LAST_BIT) begin
                        oe_nxt = ~read_r & ~tx_r[7];
                     end else begin
                        oe_nxt = read_r & ack_r;
                     end
                  end
                  2'h1: scl_nxt = 1'b1;
                  2'h2: begin
                     if (bit_r != LAST_BIT) begin
                        rx_nxt = {rx_r[6:0], sda_b_r};
                     end else begin
                        gotack_nxt = read_r ? ack_r : ~sda_b_r;
                     end
                  end
                  default: begin
                     scl_nxt = 1'b0;
                     tx_nxt = {tx_r[6:0], 1'b0};
                     bit_nxt = bit_r + 1'b1;
                     if (bit_r == LAST_BIT) begin
                        st_nxt = stop_r ? M_STOP : M_IDLE;
                        done_nxt = ~stop_r;
                        oe_nxt = 1'b0;
                     end
                  end
               endcase
            end
         end
         M_STOP: begin
            if (tick) begin
               case (q_r)
                  2'h0: oe_nxt = 1'b1;
                  2'h1: scl_nxt = 1'b1;
                  2'h2: oe_nxt = 1'b0;
                  default: begin
                     st_nxt = M_IDLE;
                     done_nxt = 1'b1;
                  end
               endcase
            end
         end
         default: st_nxt = M_IDLE;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         st_r <= M_IDLE;
         div_r <= '0;
         q_r <= 2'h0;
         bit_r <= 4'h0;
         tx_r <= 8'h00;
         rx_r <= 8'h00;
         scl_r <= 1'b1;
         oe_r <= 1'b0;
         stop_r <= 1'b0;
         skip_r <= 1'b0;
         read_r <= 1'b0;
         ack_r <= 1'b0;
         gotack_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         div_r <= div_nxt;
         q_r <= q_nxt;
         bit_r <= bit_nxt;
         tx_r <= tx_nxt;
         rx_r <= rx_nxt;
         scl_r <= scl_nxt;
         oe_r <= oe_nxt;
         stop_r <= stop_nxt;
         skip_r <= skip_nxt;
         read_r <= read_nxt;
         ack_r <= ack_nxt;
         gotack_r <= gotack_nxt;
         done_r <= done_nxt;
      end
   end

   assign bus.scl = scl_r;
   assign bus.m_sda_oe = oe_r;
   assign rsp_valid_out = done_r;
   assign rsp_data_out = rx_r;
   assign rsp_ack_out = gotack_r;
endmodule : eep_master
`default_nettype wire

// >>> test/eep_link_props.sv
// Checker for drive and timing relations on the two-wire link.
`timescale 1ns/1ps
`default_nettype none
module eep_link_props (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic scl,
   input wire logic m_sda_oe,
   input wire logic s_sda_oe,
   input wire logic sda
);
   logic       scl_d_r;
   logic       scl_d_nxt;
   logic       sda_d_r;
   logic       sda_d_nxt;
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   // ==========================================================
   // Clock rises since the last start.
   // It saturates, so only the select byte is watched bit by bit.
   always_comb begin
      scl_d_nxt = scl;
      sda_d_nxt = sda;
      cnt_nxt   = cnt_r;
      if (scl && sda_d_r && !sda) begin
         cnt_nxt = 4'h0;
      end else if (scl && !scl_d_r && cnt_r != 4'hF) begin
         cnt_nxt = cnt_r + 4'h1;
      end
   end
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
         cnt_r   <= 4'hF;
      end else begin
         scl_d_r <= scl_d_nxt;
         sda_d_r <= sda_d_nxt;
         cnt_r   <= cnt_nxt;
      end
   end
   // ==========================================================
   // Assertions.
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);
   a_slave_moves_low: assert property (
      $changed(s_sda_oe) |-> !scl) else $error("slave moved sda, scl high");
   a_slave_high_hold: assert property (
      $rose(scl) |=> $stable(s_sda_oe) [*8])
      else $error("slave sda unstable while scl high");
   a_scl_high_len: assert property (
      $rose(scl) |-> scl [*8]) else $error("scl high phase too short");
   a_scl_low_len: assert property (
      $fell(scl) |-> !scl [*8]) else $error("scl low phase too short");
   a_start_quiet: assert property (
      scl && $fell(sda) |-> !s_sda_oe [*8])
      else $error("slave drove sda right after start");
   a_stop_standby: assert property (
      scl && $rose(sda) |-> !s_sda_oe [*8])
      else $error("slave drove sda after stop");
   a_select_quiet: assert property (
      cnt_r < 4'h8 |-> !s_sda_oe)
      else $error("slave drove sda inside select byte");
   a_start_shape: assert property (
      $rose(m_sda_oe) && scl |-> ##[1:11] !scl)
      else $error("master sda fell with scl high, no start");
endmodule : eep_link_props
`default_nettype wire

// >>> test/eeprom_i2c_read_and_poll_tb.sv
// Bench joining the link master and the EEPROM end.
`timescale 1ns/1ps
`default_nettype none
module eeprom_i2c_read_and_poll_tb;
   import eep_pkg::*;
   localparam logic [2:0] STRAPS = 3'h5;
   localparam logic [7:0] SEL_A = {TYPE_ARRAY, STRAPS, 1'b0};
   localparam logic [7:0] SEL_I = {TYPE_ID_PAGE, STRAPS, 1'b0};
   logic        clk_in = 1'b0;
   logic        srst_in = 1'b1;
   logic        wp = 1'b0, busy = 1'b0, locked = 1'b0;
   logic        ld_en = 1'b0, ld_id = 1'b0;
   logic [14:0] ld_addr = 15'h0000, addr_cnt;
   logic [7:0]  ld_data = 8'h00, c_wdata = 8'h00, r_data;
   logic        c_valid = 1'b0, c_start = 1'b0, c_stop = 1'b0;
   logic        c_skip = 1'b0, c_read = 1'b0, c_ack = 1'b0;
   logic        c_ready, r_valid, r_ack, init_busy;
   int          n_errors = 0, checks_done = 0, i;
   always #12.5 clk_in = ~clk_in;
   eep_bus_if u_eep_bus_if ();
   eep_master u_eep_master (.clk_in(clk_in), .srst_in(srst_in),
      .bus(u_eep_bus_if), .cmd_valid_in(c_valid), .cmd_ready_out(c_ready),
      .cmd_start_in(c_start), .cmd_stop_in(c_stop),
      .cmd_skip_byte_in(c_skip), .cmd_read_in(c_read), .cmd_ack_in(c_ack),
      .cmd_wdata_in(c_wdata), .rsp_valid_out(r_valid),
      .rsp_data_out(r_data), .rsp_ack_out(r_ack));
   eep_slave u_eep_slave (.clk_in(clk_in), .srst_in(srst_in),
      .bus(u_eep_bus_if), .write_protect_input_in(wp),
      .chip_select_straps_in(STRAPS), .write_cycle_busy_in(busy),
      .id_page_locked_in(locked), .load_en_in(ld_en), .load_id_in(ld_id),
      .load_addr_in(ld_addr), .load_data_in(ld_data),
      .init_busy_out(init_busy), .addr_count_out(addr_cnt));
   eep_link_props u_eep_link_props (.clk_in(clk_in), .srst_in(srst_in),
      .scl(u_eep_bus_if.scl), .m_sda_oe(u_eep_bus_if.m_sda_oe),
      .s_sda_oe(u_eep_bus_if.s_sda_oe), .sda(u_eep_bus_if.sda));
   // ==========================================================
   // Compare, access and closing tasks.
   task automatic chk_bit(input string what, input logic e, input logic g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %b seen %b", what, e, g);
      end
   endtask : chk_bit
   task automatic chk_val(input string what, input logic [15:0] e,
                          input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : chk_val
   task automatic close_out();
      if (n_errors == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out
   // One command, held until taken; waits for its response pulse.
   task automatic xfer(input logic st, sp, sk, rd, ak, input logic [7:0] wd);
      while (c_ready !== 1'b1) @(posedge clk_in);
      c_start <= st;
      c_stop  <= sp;
      c_skip  <= sk;
      c_read  <= rd;
      c_ack   <= ak;
      c_wdata <= wd;
      c_valid <= 1'b1;
      @(posedge clk_in);
      c_valid <= 1'b0;
      do @(posedge clk_in); while (r_valid !== 1'b1);
   endtask : xfer
   task automatic wb(input logic st, sp, input logic [7:0] wd, input logic e);
      xfer(st, sp, 1'b0, 1'b0, 1'b0, wd);
      chk_bit("slave ack", e, r_ack);
   endtask : wb
   task automatic rb(input logic sp, ak, input logic [7:0] e);
      xfer(1'b0, sp, 1'b0, 1'b1, ak, 8'h00);
      chk_val("read byte", {8'h00, e}, {8'h00, r_data});
   endtask : rb
   task automatic load(input logic id, input logic [14:0] a,
                       input logic [7:0] d);
      ld_en   <= 1'b1;
      ld_id   <= id;
      ld_addr <= a;
      ld_data <= d;
      @(posedge clk_in);
      ld_en   <= 1'b0;
      @(posedge clk_in);
   endtask : load
   // Dummy write of the address, repeated start, one unacked byte.
   task automatic rnd(input logic [7:0] sel, hi, lo, e);
      wb(1'b1, 1'b0, sel, 1'b1);
      wb(1'b0, 1'b0, hi, 1'b1);
      wb(1'b0, 1'b0, lo, 1'b1);
      wb(1'b1, 1'b0, sel | 8'h01, 1'b1);
      rb(1'b1, 1'b0, e);
   endtask : rnd
   // The erase sweep alone takes about 33k cycles of this budget.
   initial begin
      repeat (80000) @(posedge clk_in);
      n_errors++;
      close_out();
   end
   // ==========================================================
   // Scenarios.
   initial begin
      repeat (10) @(posedge clk_in);
      srst_in <= 1'b0;
      do @(posedge clk_in); while (init_busy !== 1'b0);
      load(1'b0, 15'h7FFF, 8'h5A);
      load(1'b0, 15'h0000, 8'hC3);
      load(1'b0, 15'h0001, 8'h3C);
      load(1'b0, 15'h0123, 8'h96);
      load(1'b1, 15'h0005, 8'h77);
      busy <= 1'b1;
      wp   <= 1'b1;
      wb(1'b1, 1'b0, SEL_A, 1'b0);
      busy <= 1'b0;
      wb(1'b1, 1'b0, SEL_A, 1'b1);
      wb(1'b0, 1'b0, 8'h7F, 1'b1);
      wb(1'b0, 1'b0, 8'hFF, 1'b1);
      wb(1'b1, 1'b0, SEL_A | 8'h01, 1'b1);
      rb(1'b0, 1'b1, 8'h5A);
      rb(1'b0, 1'b1, 8'hC3);
      rb(1'b1, 1'b0, 8'h3C);
      chk_val("addr count", 16'h0002, {1'b0, addr_cnt});
      wb(1'b1, 1'b0, SEL_A | 8'h01, 1'b1);
      rb(1'b1, 1'b0, ERASED_BYTE);
      chk_val("addr count", 16'h0003, {1'b0, addr_cnt});
      wb(1'b1, 1'b1, {TYPE_ARRAY, 3'h2, 1'b0}, 1'b0);
      rnd(SEL_A, 8'h01, 8'h23, 8'h96);
      rnd(SEL_I, 8'h00, 8'h05, 8'h77);
      for (i = 0; i < 2; i++) begin
         locked <= i[0];
         wb(1'b1, 1'b0, SEL_I, 1'b1);
         wb(1'b0, 1'b0, 8'h04, 1'b1);
         wb(1'b0, 1'b0, 8'h00, 1'b1);
         wb(1'b0, 1'b0, 8'h02, ~i[0]);
         xfer(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
         // A stop alone with the clock high would glitch a start.
         xfer(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00);
      end
      rnd(SEL_I, 8'h00, 8'h00, ERASED_BYTE);
      close_out();
   end
endmodule : eeprom_i2c_read_and_poll_tb
`default_nettype wire
